//--- rtl/bpm_pkg.sv
// Purpose: Shared constants and carriers for the ballast power mode control block
// Assumes: 20 MHz system clock, comparator results arrive as logic levels
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave
package bpm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ          = 20;
  localparam int SAVE_DWELL_US    = 10;
  localparam int IDLE_TIMEOUT_US  = 100;
  localparam int SAVE_DWELL_CYC   = SAVE_DWELL_US * CLK_MHZ;
  localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_US * CLK_MHZ;
  localparam int CNT_W            = 12;
  localparam logic [CNT_W-1:0] SAVE_DWELL_CNT   = CNT_W'(SAVE_DWELL_CYC);
  localparam logic [CNT_W-1:0] IDLE_TIMEOUT_CNT = CNT_W'(IDLE_TIMEOUT_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam int          CTRL_DRV_BIT  = 0;
  localparam logic        CTRL_DRV_RST  = 1'b1;
  localparam int          STAT_MODE_LSB   = 0;
  localparam int          STAT_FAULT_BIT  = 2;
  localparam int          STAT_SWITCH_BIT = 3;
  localparam int          STAT_CHARGE_BIT = 4;
  localparam int          STAT_VREF_BIT   = 5;
  localparam int          STAT_BOOT_BIT   = 6;
  localparam int          STAT_GATE_LSB   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_STARTUP,
    MODE_SAVE,
    MODE_OPERATING,
    MODE_SHUTDOWN
  } bpm_mode_t;

  typedef struct packed {
    logic low_side_gate_input;
    logic high_side_gate_input;
    logic power_factor_input;
    logic heater_input;
  } bpm_gate_in_t;

  typedef struct packed {
    logic low_side_gate_out;
    logic high_side_gate_out;
    logic power_factor_gate_out;
    logic heater_gate_out;
  } bpm_gate_out_t;

  typedef struct packed {
    logic vcc_above_turn_on;
    logic vcc_above_save_low;
    logic vcc_above_vref_off;
    logic vcc_above_uvlo;
    logic vref_above_enable;
    logic vref_above_uv;
    logic vcc_above_reg_start;
    logic vcc_above_reg_on;
    logic vcc_above_reg_off;
    logic sense_above_ref;
    logic boot_above_supply;
  } bpm_cmp_t;

  localparam int SYNC_W = $bits(bpm_gate_in_t) + $bits(bpm_cmp_t);

endpackage : bpm_pkg

//--- rtl/bpm_input_sync.sv
// Purpose: Three-flop synchroniser with agreement filter for pin-level inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Output changes only when stages two and three agree
module bpm_input_sync
  import bpm_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] stable_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] agree = ~(stage2 ^ stage3);
  wire  [W-1:0] next_stable = (agree & stage3) | (~agree & stable_out);

  // Stage one feeds stage two only; metastability stays out of the filter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1     <= '0;
      stage2     <= '0;
      stage3     <= '0;
      stable_out <= '0;
    end else begin
      stage1     <= async_in;
      stage2     <= stage1;
      stage3     <= stage2;
      stable_out <= next_stable;
    end
  end

endmodule : bpm_input_sync

//--- rtl/bpm_power_mode_control.sv
// Purpose: Supply mode sequencing, gate gating, regulator, fault latch, register slave
// Assumes: Comparator results and logic inputs are asynchronous levels
// Notes:   Every output is registered; mode and outputs change on the same edge
////////////////////////////////////////////////////////////////////////////////
module bpm_power_mode_control
  import bpm_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire bpm_gate_in_t      gate_in,
  input  wire bpm_cmp_t          cmp_in,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output bpm_gate_out_t          gate_out,
  output logic                   high_voltage_charger_on,
  output logic                   vref_enable,
  output logic                   vref_high_current,
  output logic                   vref_sink_enable,
  output logic                   supply_switch,
  output logic                   bootstrap_switch_on,
  output logic                   current_fault_output
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [SYNC_W-1:0] sync_out;
  bpm_gate_in_t      gin;
  bpm_cmp_t          cmp;
  bpm_gate_in_t      gin_prev;

  bpm_input_sync #(
    .W          (SYNC_W)
  ) u_sync (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .async_in   ({gate_in, cmp_in}),
    .stable_out (sync_out)
  );

  assign gin = bpm_gate_in_t'(sync_out[SYNC_W-1 -: $bits(bpm_gate_in_t)]);
  assign cmp = bpm_cmp_t'(sync_out[$bits(bpm_cmp_t)-1:0]);

  wire ls_fall = gin_prev.low_side_gate_input & ~gin.low_side_gate_input;
  wire ls_edge = gin_prev.low_side_gate_input ^ gin.low_side_gate_input;
  wire hs_fall = gin_prev.high_side_gate_input & ~gin.high_side_gate_input;

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  bpm_mode_t        mode;
  bpm_mode_t        next_mode;
  logic [CNT_W-1:0] dwell_cnt;
  logic [CNT_W-1:0] idle_cnt;
  logic             drv_allow;

  wire dwell_done   = (dwell_cnt == SAVE_DWELL_CNT);
  wire idle_expired = (idle_cnt == IDLE_TIMEOUT_CNT);
  wire supply_fault = ~cmp.vcc_above_uvlo | ~cmp.vref_above_uv;

  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_STARTUP: begin
        if (cmp.vcc_above_turn_on) begin
          next_mode = MODE_SAVE;
        end
      end
      MODE_SAVE: begin
        if (!cmp.vcc_above_vref_off) begin
          next_mode = MODE_STARTUP;
        end else if (dwell_done && cmp.vref_above_enable && hs_fall) begin
          next_mode = MODE_OPERATING;
        end
      end
      MODE_OPERATING: begin
        if (supply_fault) begin
          next_mode = MODE_SHUTDOWN;
        end else if (idle_expired) begin
          next_mode = MODE_SAVE;
        end
      end
      MODE_SHUTDOWN: begin
        if (!cmp.vcc_above_vref_off) begin
          next_mode = MODE_STARTUP;
        end else if (cmp.vcc_above_turn_on) begin
          next_mode = MODE_SAVE;
        end
      end
      default: begin
        next_mode = MODE_STARTUP;
      end
    endcase
  end

  wire next_op = (next_mode == MODE_OPERATING);

  // Counters saturate so a long stay never wraps into a false expiry
  wire [CNT_W-1:0] next_dwell = (mode != MODE_SAVE) ? '0 :
                                dwell_done ? dwell_cnt : dwell_cnt + 1'b1;
  wire [CNT_W-1:0] next_idle  = (mode != MODE_OPERATING || ls_edge) ? '0 :
                                idle_expired ? idle_cnt : idle_cnt + 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Supply outputs
  logic fault;

  // Save hysteresis: start charging below the low mark, stop at turn-on
  wire save_charge  = ~cmp.vcc_above_save_low |
                      (high_voltage_charger_on & ~cmp.vcc_above_turn_on);
  wire next_charger = (next_mode == MODE_STARTUP)  ? 1'b1 :
                      (next_mode == MODE_SHUTDOWN) ? 1'b1 :
                      (next_mode == MODE_SAVE)     ? save_charge : 1'b0;
  wire next_vref    = (next_mode != MODE_STARTUP) & cmp.vcc_above_vref_off;
  wire next_vref_hi = next_op & next_vref;

  // Regulator holds its state between falling edges, except above the start threshold (on) or outside operating (off)
  wire next_switch  = !next_op ? 1'b0 :
                      cmp.vcc_above_reg_start ? 1'b1 :
                      (ls_fall && cmp.vcc_above_reg_on) ? 1'b1 :
                      (ls_fall && !cmp.vcc_above_reg_off) ? 1'b0 :
                      supply_switch;

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch and gate drives
  wire fault_set   = (mode == MODE_OPERATING) & cmp.sense_above_ref;
  wire fault_rel   = ~gin.low_side_gate_input & ~gin.high_side_gate_input &
                     ~cmp.sense_above_ref;
  wire next_fault  = fault_set | (fault & ~fault_rel);
  wire overlap     = gin.low_side_gate_input & gin.high_side_gate_input;
  wire drv_on      = next_op & drv_allow;
  wire bridge_ok   = drv_on & ~next_fault & ~overlap;

  bpm_gate_out_t next_gate;
  assign next_gate.low_side_gate_out     = bridge_ok & gin.low_side_gate_input;
  assign next_gate.high_side_gate_out    = bridge_ok & gin.high_side_gate_input;
  assign next_gate.power_factor_gate_out = drv_on & gin.power_factor_input;
  assign next_gate.heater_gate_out       = drv_on & gin.heater_input;

  // Blocking reverse flow costs soft switching, accepted for safety
  wire next_boot = next_gate.low_side_gate_out & ~cmp.boot_above_supply;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait state per access
  wire             bus_req   = avs_read | avs_write;
  wire             bus_done  = bus_req & ~avs_waitrequest;
  wire             next_wait = ~(bus_req & avs_waitrequest);
  wire             hit_ctrl  = (avs_address == REG_CTRL);
  wire             hit_stat  = (avs_address == REG_STATUS);
  wire             ctrl_wr   = bus_done & avs_write & hit_ctrl & avs_byteenable[0];
  wire             next_allow = ctrl_wr ? avs_writedata[CTRL_DRV_BIT] : drv_allow;
  wire [31:0]      ctrl_word = 32'(drv_allow) << CTRL_DRV_BIT;
  wire [31:0]      stat_word = (32'(mode) << STAT_MODE_LSB) |
                               (32'(fault) << STAT_FAULT_BIT) |
                               (32'(supply_switch) << STAT_SWITCH_BIT) |
                               (32'(high_voltage_charger_on) << STAT_CHARGE_BIT) |
                               (32'(vref_enable) << STAT_VREF_BIT) |
                               (32'(bootstrap_switch_on) << STAT_BOOT_BIT) |
                               (32'(gate_out) << STAT_GATE_LSB);
  wire [31:0]      read_word = hit_ctrl ? ctrl_word : hit_stat ? stat_word : 32'h0;
  wire             rd_load   = avs_read & avs_waitrequest;
  wire [31:0]      next_rdata = rd_load ? read_word : avs_readdata;

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode      <= MODE_STARTUP;
      gin_prev  <= '0;
      dwell_cnt <= '0;
      idle_cnt  <= '0;
      fault     <= 1'b0;
      drv_allow <= CTRL_DRV_RST;
    end else begin
      mode      <= next_mode;
      gin_prev  <= gin;
      dwell_cnt <= next_dwell;
      idle_cnt  <= next_idle;
      fault     <= next_fault;
      drv_allow <= next_allow;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_out                <= '0;
      high_voltage_charger_on <= 1'b1;
      vref_enable             <= 1'b0;
      vref_high_current       <= 1'b0;
      vref_sink_enable        <= 1'b1;
      supply_switch           <= 1'b0;
      bootstrap_switch_on     <= 1'b0;
      current_fault_output    <= 1'b0;
      avs_waitrequest         <= 1'b1;
      avs_readdata            <= 32'h0;
    end else begin
      gate_out                <= next_gate;
      high_voltage_charger_on <= next_charger;
      vref_enable             <= next_vref;
      vref_high_current       <= next_vref_hi;
      vref_sink_enable        <= ~next_vref;
      supply_switch           <= next_switch;
      bootstrap_switch_on     <= next_boot;
      current_fault_output    <= next_fault;
      avs_waitrequest         <= next_wait;
      avs_readdata            <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_STARTUP_QUIET: assert property (
    mode == MODE_STARTUP |-> high_voltage_charger_on && vref_sink_enable && !vref_enable && !supply_switch)
    else $error("start-up mode not quiet");
  AST_STARTUP_TO_SAVE: assert property (
    mode == MODE_STARTUP && cmp.vcc_above_turn_on |=> mode == MODE_SAVE)
    else $error("turn-on threshold did not enter save");
  AST_SAVE_RECHARGE: assert property (
    mode == MODE_SAVE && !cmp.vcc_above_save_low |=> high_voltage_charger_on || mode == MODE_OPERATING)
    else $error("save mode did not recharge");
  AST_OP_CHARGER_OFF: assert property (
    mode == MODE_OPERATING |-> !high_voltage_charger_on)
    else $error("charger on while operating");
  AST_SWITCH_ONLY_OP: assert property (
    mode != MODE_OPERATING |-> !supply_switch)
    else $error("supply switch on outside operating");
  AST_SWITCH_START: assert property (
    cmp.vcc_above_reg_start ##1 mode == MODE_OPERATING |-> supply_switch)
    else $error("switch not on above start threshold");
  AST_SWITCH_OFF_EDGE: assert property (
    mode == MODE_OPERATING && ls_fall && !cmp.vcc_above_reg_off && !cmp.vcc_above_reg_on &&
    !cmp.vcc_above_reg_start |=> !supply_switch)
    else $error("switch not off at falling edge");
  AST_SWITCH_ON_EDGE: assert property (
    mode == MODE_OPERATING && !supply_switch && !ls_fall && !cmp.vcc_above_reg_start
    |=> !supply_switch || $past(ls_fall) || $past(cmp.vcc_above_reg_start))
    else $error("switch turned on without falling edge");
  AST_VREF_CURRENT: assert property (
    (mode == MODE_SAVE |-> !vref_high_current) and (vref_high_current |-> mode == MODE_OPERATING))
    else $error("reference current mode wrong");
  AST_VREF_OFF: assert property (
    !cmp.vcc_above_vref_off |=> !vref_enable && vref_sink_enable)
    else $error("reference stayed on below turn-off");
  AST_AUX_GATES: assert property (
    gate_out.power_factor_gate_out || gate_out.heater_gate_out |-> mode == MODE_OPERATING)
    else $error("aux gate on outside operating");
  AST_BOOT_SYNC: assert property (
    bootstrap_switch_on |-> gate_out.low_side_gate_out && !$past(cmp.boot_above_supply))
    else $error("bootstrap switch misbehaved");
  AST_STARTUP_GATES: assert property (
    mode == MODE_STARTUP |-> gate_out == '0)
    else $error("gate driven during start-up");
  AST_FAULT_SET: assert property (
    mode == MODE_OPERATING && cmp.sense_above_ref |=> current_fault_output)
    else $error("over-current not latched");
  AST_FAULT_FORCE: assert property (
    current_fault_output |-> !gate_out.low_side_gate_out && !gate_out.high_side_gate_out)
    else $error("half-bridge driven during fault");
  AST_FAULT_RELEASE: assert property (
    $fell(current_fault_output) |-> $past(fault_rel))
    else $error("fault cleared without release condition");
  AST_INTERLOCK: assert property (
    overlap |=> !gate_out.low_side_gate_out && !gate_out.high_side_gate_out)
    else $error("cross-conduction not blocked");
  AST_ENTER_OP: assert property (
    mode == MODE_OPERATING && $past(mode) != MODE_OPERATING |-> $past(dwell_done && hs_fall && cmp.vref_above_enable))
    else $error("operating entered without dwell and edge");
  AST_IDLE_BOUND: assert property (
    mode == MODE_OPERATING && idle_expired && !supply_fault |=> mode == MODE_SAVE)
    else $error("idle timeout ignored");
  AST_UV_SHUTDOWN: assert property (
    mode == MODE_OPERATING && supply_fault |=> mode == MODE_SHUTDOWN)
    else $error("under-voltage did not shut down");
  AST_OVERCURRENT_GATED: assert property (
    mode != MODE_OPERATING && !current_fault_output |=> !current_fault_output)
    else $error("fault set outside operating");

  COV_OPERATING: cover property (mode == MODE_SAVE ##1 mode == MODE_OPERATING);
  COV_FAULT:     cover property ($rose(current_fault_output) ##[1:50] $fell(current_fault_output));
  COV_TIMEOUT:   cover property (mode == MODE_OPERATING && idle_expired ##1 mode == MODE_SAVE);
  COV_SHUTDOWN:  cover property (mode == MODE_SHUTDOWN ##1 mode == MODE_SAVE);

endmodule : bpm_power_mode_control

//--- verification/bpm_mcu_model.sv
// Purpose: Controller stand-in driving the four logic inputs of the block
// Assumes: The bench supplies the wanted input levels
// Notes:   A lag lets the controller answer promptly or slowly
module bpm_mcu_model
  import bpm_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire bpm_gate_in_t want,
  input  wire logic [3:0]   lag,
  output bpm_gate_in_t      gate_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] wait_cnt;

  // All four levels move together, so a release drops both half-bridge inputs at once
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_in  <= '0;
      wait_cnt <= '0;
    end else if (want == gate_in) begin
      wait_cnt <= '0;
    end else if (wait_cnt >= lag) begin
      gate_in  <= want;
      wait_cnt <= '0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // bpm_mcu_model

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the ballast power mode control block
// Assumes: Controller model drives the logic inputs, bench drives comparators
// Notes:   Expected gate levels come from a small mode model kept here
module tb_top
  import bpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          sys_clk = 1'b0;
  logic          reset_n = 1'b0;
  bpm_gate_in_t  cmd;
  bpm_gate_in_t  gate_in;
  bpm_cmp_t      cmp;
  bpm_gate_out_t gout;
  logic [3:0]    addr;
  logic [3:0]    lag;
  logic [31:0]   wdata;
  logic [31:0]   rdata;
  logic [31:0]   rd_word;
  logic [3:0]    be;
  logic          rd, wr, wait_r, chg, ven, vhi, vsink, sw_seen, boot, flt;
  int            failures, n_compared, m_mode;
  logic          m_fault, m_allow;

  always #25 sys_clk = ~sys_clk;

  bpm_mcu_model mcu (.sys_clk(sys_clk), .reset_n(reset_n), .want(cmd), .lag(lag), .gate_in(gate_in));

  bpm_power_mode_control DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .gate_in(gate_in), .cmp_in(cmp),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_r),
    .gate_out(gout), .high_voltage_charger_on(chg), .vref_enable(ven),
    .vref_high_current(vhi), .vref_sink_enable(vsink), .supply_switch(sw_seen),
    .bootstrap_switch_on(boot), .current_fault_output(flt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Pin to output takes up to five edges; the model lag adds more
  task automatic settle;
    repeat (8 + lag) @(posedge sys_clk);
  endtask

  task automatic apply(input bpm_gate_in_t g);
    @(posedge sys_clk);
    cmd <= g;
    settle;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    rd    <= ~w;
    wr    <= w;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge sys_clk);
    end while (wait_r !== 1'b0);
    rd_word = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic check_mode(input int m);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("mode", 32'(rd_word[1:0]), 32'(m));
  endtask

  task automatic check_gates;
    bpm_gate_out_t e;
    logic          ilk;
    e   = '0;
    ilk = (gate_in.low_side_gate_input & gate_in.high_side_gate_input) | m_fault;
    if (m_mode == 2 && m_allow) begin
      e.low_side_gate_out     = gate_in.low_side_gate_input & ~ilk;
      e.high_side_gate_out    = gate_in.high_side_gate_input & ~ilk;
      e.power_factor_gate_out = gate_in.power_factor_input;
      e.heater_gate_out       = gate_in.heater_input;
    end
    chk("gates", 32'(gout), 32'(e));
    chk("boot", 32'(boot), 32'(e.low_side_gate_out & ~cmp.boot_above_supply));
  endtask

  task automatic enter_operating;
    @(posedge sys_clk);
    cmp.vref_above_enable <= 1'b1;
    repeat (SAVE_DWELL_CYC) @(posedge sys_clk);
    apply(4'h4);
    apply(4'h0);
    m_mode = 2;
    check_mode(2);
  endtask

  task automatic pulse_low;
    apply(4'h8);
    apply(4'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    failures++;
    test_done;
  end

  initial begin
    cmd = '0; cmp = '0; addr = '0; rd = 1'b0; wr = 1'b0; wdata = '0; lag = '0; be = 4'hf;
    failures = 0; n_compared = 0; m_mode = 0; m_fault = 1'b0; m_allow = 1'b1;
    void'($urandom(92764));
    repeat (5) @(posedge sys_clk);
    chk("charger", 32'(chg), 32'h1);
    chk("sink", 32'(vsink), 32'h1);
    reset_n <= 1'b1;
    apply(4'hf);
    check_gates;
    check_mode(0);
    @(posedge sys_clk);
    // Supplies good, reference not yet at its enabling level
    cmp <= 11'h7a0;
    apply(4'h0);
    m_mode = 1;
    check_mode(1);
    chk("vref_on", 32'(ven), 32'h1);
    chk("vref_hi", 32'(vhi), 32'h0);
    chk("charger", 32'(chg), 32'h0);
    @(posedge sys_clk);
    cmp.vcc_above_save_low <= 1'b0;
    cmp.vcc_above_turn_on  <= 1'b0;
    settle;
    chk("charger", 32'(chg), 32'h1);
    @(posedge sys_clk);
    cmp.vcc_above_save_low <= 1'b1;
    cmp.vcc_above_turn_on  <= 1'b1;
    enter_operating;
    chk("charger", 32'(chg), 32'h0);
    chk("vref_hi", 32'(vhi), 32'h1);
    lag <= 4'h3;
    for (int i = 0; i < 24; i++) begin
      cmp.boot_above_supply <= 1'($urandom);
      apply(4'($urandom));
      check_gates;
    end
    lag <= 4'h0;
    cmp.boot_above_supply <= 1'b0;
    apply(4'h0);
    // Regulator bands: start, then off, then on
    cmp.vcc_above_reg_start <= 1'b1;
    cmp.vcc_above_reg_on    <= 1'b1;
    cmp.vcc_above_reg_off   <= 1'b1;
    settle;
    chk("switch", 32'(sw_seen), 32'h1);
    {cmp.vcc_above_reg_start, cmp.vcc_above_reg_on, cmp.vcc_above_reg_off} <= 3'h0;
    settle;
    chk("switch", 32'(sw_seen), 32'h1);
    pulse_low;
    chk("switch", 32'(sw_seen), 32'h0);
    {cmp.vcc_above_reg_on, cmp.vcc_above_reg_off} <= 2'h3;
    settle;
    chk("switch", 32'(sw_seen), 32'h0);
    pulse_low;
    chk("switch", 32'(sw_seen), 32'h1);
    cmd <= 4'h8;
    cmp.sense_above_ref <= 1'b1;
    settle;
    m_fault = 1'b1;
    chk("fault", 32'(flt), 32'h1);
    check_gates;
    cmp.sense_above_ref <= 1'b0;
    settle;
    chk("fault", 32'(flt), 32'h1);
    apply(4'h0);
    m_fault = 1'b0;
    chk("fault", 32'(flt), 32'h0);
    bus(1'b1, REG_CTRL, 32'h0);
    m_allow = 1'b0;
    apply(4'h3);
    check_gates;
    bus(1'b1, REG_CTRL, 32'h1);
    m_allow = 1'b1;
    // A write without lane zero must leave the control bit alone
    be <= 4'he;
    bus(1'b1, REG_CTRL, 32'h0);
    be <= 4'hf;
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_lane", rd_word, 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", rd_word, 32'h0);
    repeat (IDLE_TIMEOUT_CYC + 20) @(posedge sys_clk);
    m_mode = 1;
    check_mode(1);
    chk("switch", 32'(sw_seen), 32'h0);
    cmp.sense_above_ref <= 1'b1;
    settle;
    chk("fault", 32'(flt), 32'h0);
    cmp.sense_above_ref <= 1'b0;
    apply(4'h0);
    enter_operating;
    {cmp.vcc_above_uvlo, cmp.vcc_above_turn_on} <= 2'h0;
    settle;
    check_mode(3);
    chk("charger", 32'(chg), 32'h1);
    {cmp.vcc_above_uvlo, cmp.vcc_above_turn_on} <= 2'h3;
    settle;
    check_mode(1);
    cmp.vcc_above_vref_off <= 1'b0;
    settle;
    chk("vref_on", 32'(ven), 32'h0);
    chk("sink", 32'(vsink), 32'h1);
    check_mode(0);
    test_done;
  end
endmodule // tb_top
